// ### design/gsr_event_reg.sv
// Purpose: Latching event register with enable mask and summary
// Assumes: Conditions are synchronous to sys_clk_i
// Notes: No write path into the event bits
`timescale 1ns/1ps
`default_nettype none
module gsr_event_reg import gsr_pkg::*; #(
  parameter int W = 8,
  parameter logic [W-1:0] USED = '1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] cond_i,
  input wire logic clear_i,
  input wire logic mask_we_i,
  input wire logic [W-1:0] mask_i,
  output logic [W-1:0] event_o,
  output logic [W-1:0] mask_o,
  output logic summary_o
);
  logic [W-1:0] ev_q, ev_d, mk_q, mk_d;
  logic sum_q, sum_d;

  always_comb begin
    // Set wins over clear so no event is lost
    ev_d = clear_i ? '0 : ev_q;
    ev_d = ev_d | (cond_i & USED);
    mk_d = mask_we_i ? mask_i : mk_q;
    // Clear drops the summary with the bits, no stale pulse
    sum_d = |(ev_q & mk_q) && !clear_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ev_q <= '0;
      mk_q <= '0;
      sum_q <= 1'b0;
    end else begin
      ev_q <= ev_d;
      mk_q <= mk_d;
      sum_q <= sum_d;
    end
  end

  assign event_o = ev_q;
  assign mask_o = mk_q;
  assign summary_o = sum_q;
endmodule
`default_nettype wire

// ### design/gsr_pkg.sv
// Purpose: Shared constants and carrier types for the status reporting block
// Assumes: One 100 MHz clock domain
// Notes: Bit positions follow the status byte layout
package gsr_pkg;
  localparam int GSR_STB_W = 8;
  localparam int GSR_DEV_W = 16;
  localparam int GSR_STD_W = 8;
  localparam int GSR_BIT_DSB = 3;
  localparam int GSR_BIT_MAV = 4;
  localparam int GSR_BIT_ESB = 5;
  localparam int GSR_BIT_MSS = 6;
  localparam logic [7:0] GSR_SRE_RST = 8'h00;
  localparam logic [7:0] GSR_ESE_RST = 8'h00;
  localparam logic [15:0] GSR_DSE_RST = 16'h0000;
  localparam logic [7:0] GSR_STD_USED = 8'hB9;
  localparam logic [7:0] GSR_STB_RST = 8'h00;

  // Command codes from the decoder
  typedef enum logic [2:0] {
    GSR_CMD_NONE = 3'h0,
    GSR_CMD_CLS = 3'h1,
    GSR_CMD_SRE = 3'h2,
    GSR_CMD_ESE = 3'h3,
    GSR_CMD_DSE = 3'h4,
    GSR_CMD_ESR_Q = 3'h5,
    GSR_CMD_DSR_Q = 3'h6,
    GSR_CMD_STB_Q = 3'h7
  } gsr_cmd_t;

  typedef struct packed {
    logic valid;
    gsr_cmd_t cmd;
    logic [15:0] value;
  } gsr_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } gsr_rsp_t;
endpackage

// ### design/gsr_srq_ctrl.sv
// Purpose: Request-service flag and bus service request line
// Assumes: Master summary is registered
// Notes: Flag sets on rising master summary
`timescale 1ns/1ps
`default_nettype none
module gsr_srq_ctrl import gsr_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic mss_i,
  input wire logic poll_done_i,
  input wire logic cls_i,
  output logic rqs_o,
  output logic srq_oe_o
);
  logic rqs_q, rqs_d, mss_prev_q, mss_prev_d;

  always_comb begin
    mss_prev_d = cls_i ? 1'b0 : mss_i;
    rqs_d = rqs_q;
    if (poll_done_i || cls_i) begin
      rqs_d = 1'b0;
    end
    if (mss_i && !mss_prev_q && !cls_i) begin
      rqs_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rqs_q <= 1'b0;
      mss_prev_q <= 1'b0;
    end else begin
      rqs_q <= rqs_d;
      mss_prev_q <= mss_prev_d;
    end
  end

  assign rqs_o = rqs_q;
  assign srq_oe_o = rqs_q;
endmodule
`default_nettype wire

// ### design/gsr_status_top.sv
// Purpose: Status reporting hierarchy of a bus instrument port
// Assumes: Commands arrive decoded on one clock; mask values already binary
// Notes: SRQ is open-drain, enable high pulls the line low
// Operation
// - Event bits latch and hold conditions
// - Event bits clear on query or clear-status
// - Event registers cannot be written
// - Masked OR of events gives summary bit
// - Every event register has writable enable mask
// - Master summary lands in status bit 6
// - Request enable bit 6 always enabled
// - Serial poll returns byte, clears request flag
// - Clear-status clears byte except bit 4, flag, summary, SRQ
// - Bit 3 follows masked device events
// - Bit 4 set while output data waits
// - Bit 5 follows masked standard events
// - Bit 6 set by any enabled status bit
// - Flag and SRQ set on master summary
// - Power-on clears the whole status byte
// - Clear-status keeps bit 4 while data waits
// - Status query leaves all bits unchanged
// - Request mask cleared by reset or zero
// - Standard register and mask clearing conditions
`timescale 1ns/1ps
`default_nettype none
module gsr_status_top import gsr_pkg::*; #(
  parameter int DEV_W = GSR_DEV_W
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire gsr_req_t req_i,
  input wire logic [DEV_W-1:0] dev_cond_i,
  input wire logic [GSR_STD_W-1:0] std_cond_i,
  input wire logic out_buf_avail_i,
  input wire logic spoll_i,
  output gsr_rsp_t rsp_o,
  output logic [GSR_STB_W-1:0] spoll_byte_o,
  output logic srq_oe_o,
  output logic [GSR_STB_W-1:0] service_status_byte_o
);
  logic rst_s1_q, rst_n;
  logic cls, dev_clr, std_clr, stb_q_rd;
  logic dev_sum, std_sum, rqs;
  logic [DEV_W-1:0] dev_ev;
  logic [GSR_STD_W-1:0] std_ev;
  logic [7:0] sre_q, sre_d, stb_q, stb_d, sp_q, sp_d;
  logic mss_q, mss_d;
  gsr_rsp_t rsp_q, rsp_d;

  function automatic logic is_cmd(gsr_req_t r, gsr_cmd_t c);
    return r.valid && (r.cmd == c);
  endfunction

  // Reset release synchroniser
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  assign cls = is_cmd(req_i, GSR_CMD_CLS);
  assign dev_clr = cls || is_cmd(req_i, GSR_CMD_DSR_Q);
  assign std_clr = cls || is_cmd(req_i, GSR_CMD_ESR_Q);
  assign stb_q_rd = is_cmd(req_i, GSR_CMD_STB_Q);

  gsr_event_reg #(.W(DEV_W), .USED('1)) u_dev (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .cond_i(dev_cond_i),
    .clear_i(dev_clr),
    .mask_we_i(is_cmd(req_i, GSR_CMD_DSE)),
    .mask_i(req_i.value[DEV_W-1:0]),
    .event_o(dev_ev),
    .mask_o(),
    .summary_o(dev_sum)
  );

  gsr_event_reg #(.W(GSR_STD_W), .USED(GSR_STD_USED)) u_std (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .cond_i(std_cond_i),
    .clear_i(std_clr),
    .mask_we_i(is_cmd(req_i, GSR_CMD_ESE)),
    .mask_i(req_i.value[GSR_STD_W-1:0]),
    .event_o(std_ev),
    .mask_o(),
    .summary_o(std_sum)
  );

  gsr_srq_ctrl u_srq (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .mss_i(mss_q),
    .poll_done_i(spoll_i),
    .cls_i(cls),
    .rqs_o(rqs),
    .srq_oe_o(srq_oe_o)
  );

  always_comb begin
    stb_d = GSR_STB_RST;
    // Summaries drop the cycle a clearing read empties the source
    stb_d[GSR_BIT_DSB] = dev_sum && !dev_clr;
    stb_d[GSR_BIT_ESB] = std_sum && !std_clr;
    stb_d[GSR_BIT_MAV] = out_buf_avail_i;
    // Bit 6 of the mask is ignored in the summary term
    // Taken from the next byte so bit 6 never outlives its cause
    mss_d = |(stb_d & sre_q & ~(8'h01 << GSR_BIT_MSS));
    if (cls) begin
      mss_d = 1'b0;
    end
    stb_d[GSR_BIT_MSS] = mss_d;
    sre_d = sre_q;
    if (is_cmd(req_i, GSR_CMD_SRE)) begin
      sre_d = req_i.value[7:0] | (8'h01 << GSR_BIT_MSS);
    end
    // Poll byte: bits 0-5, 7 and request flag in bit 6
    sp_d = {stb_q[7], rqs, stb_q[5:0]};
    rsp_d.valid = 1'b0;
    rsp_d.data = 16'h0000;
    if (stb_q_rd) begin
      rsp_d.valid = 1'b1;
      rsp_d.data = {8'h00, stb_q};
    end else if (is_cmd(req_i, GSR_CMD_ESR_Q)) begin
      rsp_d.valid = 1'b1;
      rsp_d.data = {8'h00, std_ev};
    end else if (is_cmd(req_i, GSR_CMD_DSR_Q)) begin
      rsp_d.valid = 1'b1;
      rsp_d.data = 16'(dev_ev);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      stb_q <= GSR_STB_RST;
      mss_q <= 1'b0;
      sre_q <= GSR_SRE_RST | (8'h01 << GSR_BIT_MSS);
      sp_q <= 8'h00;
      rsp_q <= '0;
    end else begin
      stb_q <= stb_d;
      mss_q <= mss_d;
      sre_q <= sre_d;
      sp_q <= sp_d;
      rsp_q <= rsp_d;
    end
  end

  assign rsp_o = rsp_q;
  assign spoll_byte_o = sp_q;
  assign service_status_byte_o = stb_q;
endmodule
`default_nettype wire

// ### sim/gsr_chk_assertions.sv
// Purpose: Port checker for gsr_status_top
// Assumes: One clock, reset low active
// Notes: Bound to the top below
`timescale 1ns/1ps
`default_nettype none
module gsr_chk import gsr_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire gsr_req_t req_i,
  input wire logic out_buf_avail_i,
  input wire logic spoll_i,
  input wire gsr_rsp_t rsp_o,
  input wire logic [7:0] spoll_byte_o,
  input wire logic srq_oe_o,
  input wire logic [7:0] service_status_byte_o
);
  wire logic [7:0] sb = service_status_byte_o;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_cls;
    req_i.valid && req_i.cmd == GSR_CMD_CLS;
  endsequence
  sequence s_qry;
    req_i.valid && req_i.cmd >= GSR_CMD_ESR_Q;
  endsequence
  a_unused_zero: assert property (sb[2:0] == 3'h0 && !sb[7])
    else $error("unused status bit set");
  a_mav_clear: assert property (!out_buf_avail_i [*4] |-> !sb[4])
    else $error("MAV set with empty buffer");
  a_mss_cause: assert property (sb[6] |-> sb[5:3] != 3'h0)
    else $error("MSS without a summary bit");
  a_rqs_srq: assert property ($rose(sb[6]) |-> ##[0:2] srq_oe_o)
    else $error("no service request after MSS");
  a_poll_clear: assert property (spoll_i |-> ##[1:3] !spoll_byte_o[6])
    else $error("RQS kept after poll");
  a_cls_clear: assert property
    (s_cls |-> ##[1:2] (!srq_oe_o && !spoll_byte_o[6]))
    else $error("request kept after clear");
  a_cls_mav: assert property (s_cls ##0 (sb[4] && out_buf_avail_i)
    ##1 out_buf_avail_i |-> sb[4]) else $error("MAV lost on clear");
  a_qry_rsp: assert property (s_qry |-> ##1 rsp_o.valid)
    else $error("query not answered");
endmodule
bind gsr_status_top gsr_chk gsr_chk_inst (.sys_clk_i, .nrst_i, .req_i,
  .out_buf_avail_i, .spoll_i, .rsp_o, .spoll_byte_o, .srq_oe_o,
  .service_status_byte_o);
`default_nettype wire

// ### sim/gsr_ctl.sv
// Purpose: Bus controller model issuing commands and polls
// Assumes: Calls start right after a rising edge
// Notes: Leaves an idle cycle after each request
`timescale 1ns/1ps
`default_nettype none
module gsr_ctl import gsr_pkg::*; (
  input wire logic clk_i,
  output gsr_req_t req_o,
  output logic poll_o
);
  initial begin
    req_o = '0;
    poll_o = 1'b0;
  end
  task automatic cmd(input gsr_cmd_t c, input logic [15:0] v);
    req_o <= '{1'b1, c, v};
    @(posedge clk_i);
    req_o <= '0;
    @(posedge clk_i);
  endtask
  task automatic poll;
    poll_o <= 1'b1;
    @(posedge clk_i);
    poll_o <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ### sim/tb.sv
// Purpose: Self-checking bench for gsr_status_top
// Assumes: Controller model drives commands
// Notes: Values read at edges are pre-edge
`timescale 1ns/1ps
`default_nettype none
module tb import gsr_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] dc = '0;
  logic [7:0] sc = '0;
  logic av = 1'b0;
  logic po;
  logic srq;
  logic [7:0] pb;
  logic [7:0] sb;
  gsr_req_t req;
  gsr_rsp_t rsp;
  int bad_count = 0;
  int n_tests = 0;
  initial forever #5 clk = ~clk;
  gsr_status_top gsr_status_top_inst (.sys_clk_i(clk), .nrst_i(rst_n),
    .req_i(req), .dev_cond_i(dc), .std_cond_i(sc), .out_buf_avail_i(av),
    .spoll_i(po), .rsp_o(rsp), .spoll_byte_o(pb), .srq_oe_o(srq),
    .service_status_byte_o(sb));
  gsr_ctl gsr_ctl_inst (.clk_i(clk), .req_o(req), .poll_o(po));
  task automatic chk(input string n, input logic [15:0] s, e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic qry(input gsr_cmd_t c, input logic [15:0] e);
    int i;
    gsr_ctl_inst.cmd(c, 16'h0000);
    for (i = 0; i < 4 && rsp.valid !== 1'b1; i++) @(posedge clk);
    if (i == 4) begin
      bad_count++;
      report_and_stop();
    end else begin
      chk("answer", rsp.data, e);
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("stb", sb, 16'h0000);
    gsr_ctl_inst.cmd(GSR_CMD_DSE, 16'h8000);
    gsr_ctl_inst.cmd(GSR_CMD_SRE, 16'h0038);
    dc <= 16'h8000;
    @(posedge clk);
    dc <= '0;
    repeat (8) @(posedge clk);
    chk("stb", sb, 16'h0048);
    chk("srq", srq, 16'h0001);
    chk("poll", pb, 16'h0048);
    gsr_ctl_inst.poll();
    repeat (3) @(posedge clk);
    chk("poll", pb, 16'h0008);
    chk("srq", srq, 16'h0000);
    qry(GSR_CMD_STB_Q, 16'h0048);
    chk("stb", sb, 16'h0048);
    qry(GSR_CMD_DSR_Q, 16'h8000);
    repeat (4) @(posedge clk);
    chk("stb", sb, 16'h0000);
    $display("device event test done");
    gsr_ctl_inst.cmd(GSR_CMD_SRE, 16'h0000);
    gsr_ctl_inst.cmd(GSR_CMD_ESE, 16'h0020);
    av <= 1'b1;
    sc <= 8'h22;
    @(posedge clk);
    sc <= '0;
    repeat (8) @(posedge clk);
    chk("stb", sb, 16'h0030);
    qry(GSR_CMD_ESR_Q, 16'h0020);
    repeat (4) @(posedge clk);
    chk("stb", sb, 16'h0010);
    sc <= 8'h20;
    @(posedge clk);
    sc <= '0;
    repeat (6) @(posedge clk);
    gsr_ctl_inst.cmd(GSR_CMD_CLS, 16'h0000);
    repeat (3) @(posedge clk);
    chk("stb", sb, 16'h0010);
    qry(GSR_CMD_ESR_Q, 16'h0000);
    av <= 1'b0;
    repeat (5) @(posedge clk);
    chk("stb", sb, 16'h0000);
    $display("standard event test done");
    // Clear-status while a request is pending
    gsr_ctl_inst.cmd(GSR_CMD_DSE, 16'h0001);
    gsr_ctl_inst.cmd(GSR_CMD_SRE, 16'h0008);
    dc <= 16'h0001;
    @(posedge clk);
    dc <= '0;
    repeat (8) @(posedge clk);
    chk("srq", srq, 16'h0001);
    gsr_ctl_inst.cmd(GSR_CMD_CLS, 16'h0000);
    repeat (3) @(posedge clk);
    chk("stb", sb, 16'h0000);
    chk("srq", srq, 16'h0000);
    chk("poll", pb, 16'h0000);
    qry(GSR_CMD_DSR_Q, 16'h0000);
    $display("clear status test done");
    // Power-on reset in mid-run drops the device enable mask
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    dc <= 16'h0001;
    @(posedge clk);
    dc <= '0;
    repeat (8) @(posedge clk);
    chk("stb", sb, 16'h0000);
    chk("srq", srq, 16'h0000);
    qry(GSR_CMD_DSR_Q, 16'h0001);
    $display("reset test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
